// file: hw/eif_pkg.sv
// package of register map, field layout and timing constants for the external irq filter
package eif_pkg;
  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [11:0] CH2_CONTROL_ADDR = 12'hfd9;
  localparam logic [11:0] CH3_CONTROL_ADDR = 12'hfda;
  localparam logic [7:0]  CONTROL_RESET    = 8'h00;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int SAMPLE_LSB = 0;
  localparam int EDGE_LSB   = 2;
  localparam int LEVEL_BIT  = 4;

  // ****************************************************************
  // edge select codes
  // ****************************************************************
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;

  // ****************************************************************
  // timing: agreeing samples and slow-mode divider
  // ****************************************************************
  localparam int FILTER_SAMPLES = 3;
  localparam int SLOW_DIVIDE    = 4;
endpackage

// file: hw/eif_filter.sv
// one channel: sample strobe, noise canceller and edge detector
`timescale 1ns/100ps
module eif_filter #(
  parameter int SAMPLES = eif_pkg::FILTER_SAMPLES
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       gate,
  input  wire logic       slow_mode,
  input  wire logic       slow_tick,
  input  wire logic [1:0] sample_interval,
  input  wire logic [1:0] edge_select,
  input  wire logic       pin,
  output logic            filtered,
  output logic            request
);
  // ****************************************************************
  // sample strobe and filter
  // ****************************************************************
  logic [3:0] div;
  logic [3:0] next_div;
  logic [1:0] agree;
  logic [1:0] next_agree;
  logic       next_filtered;
  logic       tick;
  logic       rise;
  logic       fall;

  // divider picks the gear rate or the slow tick
  always_comb begin
    next_div      = gate ? div + 4'h1 : 4'h0;
    next_agree    = agree;
    next_filtered = filtered;
    case (sample_interval)
      2'h0:    tick = 1'b1; // [R5]
      2'h1:    tick = (div[1:0] == 2'h3); // [R5]
      2'h2:    tick = (div[2:0] == 3'h7); // [R5]
      default: tick = (div == 4'hf); // [R5]
    endcase
    if (slow_mode) begin
      tick = slow_tick; // [R6]
    end
    if (!gate) begin
      // gate low invalidates the filter state
      next_agree    = 2'h0; // [R12]
      next_filtered = 1'b0;
    end else if (tick) begin
      if (pin == filtered) begin
        next_agree = 2'h0;
      end else if (agree == 2'(SAMPLES - 1)) begin
        next_agree    = 2'h0;
        next_filtered = pin; // [R13]
      end else begin
        next_agree = agree + 2'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div      <= 4'h0;
      agree    <= 2'h0;
      filtered <= 1'b0;
    end else begin
      div      <= next_div;
      agree    <= next_agree;
      filtered <= next_filtered;
    end
  end

  // ****************************************************************
  // edge detection; mode changes may glitch, left to software
  // ****************************************************************
  assign rise = gate && !filtered && next_filtered;
  assign fall = gate && filtered && !next_filtered;

  // request registered so it lines up with the new filtered level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      request <= 1'b0;
    end else begin
      request <= (edge_select == eif_pkg::EDGE_RISE && rise)        // [R2] [R8]
              || (edge_select == eif_pkg::EDGE_FALL && fall)        // [R3]
              || (edge_select == eif_pkg::EDGE_BOTH && (rise || fall)); // [R4] [R14]
    end
  end

  filter_settle_a: assert property (@(posedge clk) disable iff (rst) // [R12]
    !gate |=> !filtered) else $error("filter not cleared by gate");
  rise_request_a: assert property (@(posedge clk) disable iff (rst) // [R2]
    (edge_select == eif_pkg::EDGE_RISE && rise) |=> request && filtered)
    else $error("missed rising request");
  fall_request_a: assert property (@(posedge clk) disable iff (rst) // [R3]
    (edge_select == eif_pkg::EDGE_FALL && fall) |=> request && !filtered)
    else $error("missed falling request");
  // keyed on the edge itself, so a settings write in the same cycle cannot trip it
  both_request_a: assert property (@(posedge clk) disable iff (rst) // [R4]
    (edge_select == eif_pkg::EDGE_BOTH && (rise || fall)) |=> request)
    else $error("missed both-edge request");
  reserved_quiet_a: assert property (@(posedge clk) disable iff (rst) // [R4]
    edge_select == 2'h3 |=> !request) else $error("request on reserved code");
  request_pulse_a: assert property (@(posedge clk) disable iff (rst) // [R14]
    request |=> !request) else $error("request longer than a cycle");
  filter_hold_a: assert property (@(posedge clk) disable iff (rst) // [R13]
    (gate && !tick) |=> $stable(filtered)) else $error("filter moved off tick");
  rise_cover_c: cover property (@(posedge clk) rise);
  fall_cover_c: cover property (@(posedge clk) fall);
endmodule

// file: hw/eif_ctl.sv
// top: two external interrupt channels with control registers
`timescale 1ns/100ps
//Contract
// R1 - bit 4 reads the filtered level caught at the last request, zero after reset
// R2 - edge code 00 requests on every rising filtered edge
// R3 - edge code 01 requests on every falling filtered edge
// R4 - edge code 10 requests on both edges; code 11 is reserved
// R5 - normal or idle mode samples at gear clock divided by 1, 4, 8, 16
// R6 - slow or sleep modes sample at low-frequency clock over four
// R7 - upper three control bits read zero
// R8 - requests during mode changes may be spurious and are not suppressed
// R9 - software disables interrupt before changing settings or mode
// R10 - after going slow, software waits twelve slow clocks then clears latch
// R11 - after going fast, software waits two gear plus three slow clocks
// R12 - gate low stops the channel and clears its control register
// R13 - filtered level changes only after several agreeing samples
// R14 - each qualifying edge gives one request pulse and captures the level
module eif_ctl #(
  parameter int SAMPLES = eif_pkg::FILTER_SAMPLES
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic [11:0] ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [7:0]  RDATA,
  input  wire logic [1:0]  CLOCK_GATE,
  input  wire logic        SLOW_MODE,
  input  wire logic        LF_CLK_IN,
  input  wire logic [1:0]  IRQ_PIN,
  output logic      [1:0]  IRQ_REQUEST
);
  // ****************************************************************
  // slow-mode sample tick from the low-frequency clock input
  // ****************************************************************
  logic       lf_q;
  logic [1:0] lf_div;
  logic [1:0] next_lf_div;
  logic       lf_edge;
  logic       slow_tick;

  // low-frequency clock is sampled as a plain synchronous input
  assign lf_edge = LF_CLK_IN && !lf_q;

  always_comb begin
    next_lf_div = lf_edge ? lf_div + 2'h1 : lf_div;
  end

  assign slow_tick = lf_edge && (lf_div == 2'(eif_pkg::SLOW_DIVIDE - 1)); // [R6]

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      lf_q   <= 1'b0;
      lf_div <= 2'h0;
    end else begin
      lf_q   <= LF_CLK_IN;
      lf_div <= next_lf_div;
    end
  end

  // ****************************************************************
  // per-channel control registers and filters
  // ****************************************************************
  logic [1:0] edge_sel   [2];
  logic [1:0] sample_int [2];
  logic [1:0] level;
  logic [1:0] filtered;
  logic [1:0] request;
  logic [1:0] sel;

  assign sel[0] = (ADDR == eif_pkg::CH2_CONTROL_ADDR);
  assign sel[1] = (ADDR == eif_pkg::CH3_CONTROL_ADDR);
  assign IRQ_REQUEST = request;

  generate
    for (genvar c = 0; c < 2; c++) begin : g_ch
      logic [1:0] next_edge;
      logic [1:0] next_sample;
      logic       next_level;

      // writes only land while the gate is open; gate low clears all
      always_comb begin
        next_edge   = edge_sel[c];
        next_sample = sample_int[c];
        next_level  = level[c];
        if (!CLOCK_GATE[c]) begin
          next_edge   = eif_pkg::CONTROL_RESET[eif_pkg::EDGE_LSB +: 2]; // [R12]
          next_sample = eif_pkg::CONTROL_RESET[eif_pkg::SAMPLE_LSB +: 2];
          next_level  = eif_pkg::CONTROL_RESET[eif_pkg::LEVEL_BIT];
        end else begin
          if (WR && sel[c]) begin
            // settings change glitches are software's to mask
            next_edge   = WDATA[eif_pkg::EDGE_LSB +: 2]; // [R9]
            next_sample = WDATA[eif_pkg::SAMPLE_LSB +: 2];
          end
          if (request[c]) begin
            next_level = filtered[c]; // [R1] [R14]
          end
        end
      end

      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          edge_sel[c]   <= eif_pkg::CONTROL_RESET[eif_pkg::EDGE_LSB +: 2];
          sample_int[c] <= eif_pkg::CONTROL_RESET[eif_pkg::SAMPLE_LSB +: 2];
          level[c]      <= eif_pkg::CONTROL_RESET[eif_pkg::LEVEL_BIT];
        end else begin
          edge_sel[c]   <= next_edge;
          sample_int[c] <= next_sample;
          level[c]      <= next_level;
        end
      end

      eif_filter #(
        .SAMPLES(SAMPLES)
      ) u_filter (
        .clk            (CLK),
        .rst            (RST),
        .gate           (CLOCK_GATE[c]),
        .slow_mode      (SLOW_MODE),
        .slow_tick      (slow_tick),
        .sample_interval(sample_int[c]),
        .edge_select    (edge_sel[c]),
        .pin            (IRQ_PIN[c]),
        .filtered       (filtered[c]),
        .request        (request[c])
      );
    end
  endgenerate

  // ****************************************************************
  // read port, data one cycle after the strobe
  // ****************************************************************
  logic [7:0] next_rdata;

  // unmapped addresses read zero; upper three bits always zero
  always_comb begin
    next_rdata = 8'h00;
    if (RD && sel[0]) begin
      next_rdata = {3'h0, level[0], edge_sel[0], sample_int[0]}; // [R7]
    end else if (RD && sel[1]) begin
      next_rdata = {3'h0, level[1], edge_sel[1], sample_int[1]}; // [R7]
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      RDATA <= 8'h00;
    end else begin
      RDATA <= next_rdata;
    end
  end

  // ****************************************************************
  // read port and write path checks
  // ****************************************************************
  // reserved bits never show on the read port
  upper_zero_a: assert property (@(posedge CLK) disable iff (RST) // [R7]
    RDATA[7:5] == 3'h0) else $error("upper bits not zero");

  // read data stand for one cycle only, zero otherwise
  idle_read_a: assert property (@(posedge CLK) disable iff (RST) // [R7]
    !RD |=> RDATA == 8'h00) else $error("read data outside read cycle");

  // addresses outside the two registers read as zero
  unmapped_read_a: assert property (@(posedge CLK) disable iff (RST) // [R7]
    (RD && !sel[0] && !sel[1]) |=> RDATA == 8'h00) else $error("unmapped read not zero");

  // readback shows the register as it stood at the strobe, not one cycle later
  readback_a: assert property (@(posedge CLK) disable iff (RST) // [R1]
    (RD && sel[0]) |=> RDATA[4] == $past(level[0]) && RDATA[3:2] == $past(edge_sel[0])
      && RDATA[1:0] == $past(sample_int[0])) else $error("bad readback");
  readback3_a: assert property (@(posedge CLK) disable iff (RST) // [R1]
    (RD && sel[1]) |=> RDATA[4] == $past(level[1]) && RDATA[3:2] == $past(edge_sel[1])
      && RDATA[1:0] == $past(sample_int[1])) else $error("bad channel 3 readback");

  // a write with the gate open lands in the next cycle
  write_land_a: assert property (@(posedge CLK) disable iff (RST) // [R12]
    (WR && sel[0] && CLOCK_GATE[0]) |=>
      edge_sel[0] == $past(WDATA[eif_pkg::EDGE_LSB +: 2]) &&
      sample_int[0] == $past(WDATA[eif_pkg::SAMPLE_LSB +: 2]))
    else $error("write did not land");

  // ****************************************************************
  // level bit checks
  // ****************************************************************
  // the level bit catches the filtered value at each request
  level_capture_a: assert property (@(posedge CLK) disable iff (RST) // [R1]
    (request[0] && CLOCK_GATE[0]) |=> level[0] == $past(filtered[0]))
    else $error("level not captured");
  level3_capture_a: assert property (@(posedge CLK) disable iff (RST) // [R1]
    (request[1] && CLOCK_GATE[1]) |=> level[1] == $past(filtered[1]))
    else $error("channel 3 level not captured");

  // without a request the level bit holds, so software sees the last edge
  level_hold_a: assert property (@(posedge CLK) disable iff (RST) // [R14]
    (!request[0] && CLOCK_GATE[0]) |=> $stable(level[0]))
    else $error("level moved without request");
  level3_hold_a: assert property (@(posedge CLK) disable iff (RST) // [R14]
    (!request[1] && CLOCK_GATE[1]) |=> $stable(level[1]))
    else $error("channel 3 level moved without request");

  // ****************************************************************
  // gate and slow tick checks
  // ****************************************************************
  // gate low holds the register at its reset value
  gate_clear_a: assert property (@(posedge CLK) disable iff (RST) // [R12]
    !CLOCK_GATE[1] |=> edge_sel[1] == 2'h0 && level[1] == 1'b0)
    else $error("gate did not clear");
  gate2_clear_a: assert property (@(posedge CLK) disable iff (RST) // [R12]
    !CLOCK_GATE[0] |=> edge_sel[0] == 2'h0 && sample_int[0] == 2'h0 && level[0] == 1'b0)
    else $error("channel 2 gate did not clear");

  // a closed gate silences the channel from the next cycle on
  gated_quiet_a: assert property (@(posedge CLK) disable iff (RST) // [R12]
    !CLOCK_GATE[0] |=> !request[0]) else $error("request with gate closed");
  gated3_quiet_a: assert property (@(posedge CLK) disable iff (RST) // [R12]
    !CLOCK_GATE[1] |=> !request[1]) else $error("channel 3 request with gate closed");

  // the slow tick is a single-cycle strobe
  slow_tick_a: assert property (@(posedge CLK) disable iff (RST) // [R6]
    slow_tick |=> !slow_tick) else $error("slow tick too long");

  // main scenarios: readback after a request, slow-mode request, gate reopening
  req_cover_c: cover property (@(posedge CLK) request[0] ##1 RD && sel[0]);
  slow_cover_c: cover property (@(posedge CLK) SLOW_MODE && request[1]);
  gate_cover_c: cover property (@(posedge CLK) !CLOCK_GATE[0] ##1 CLOCK_GATE[0]);
endmodule

// file: tb/eif_pin_model.sv
// pin-side model: drives both external interrupt pins
`timescale 1ns/100ps
module eif_pin_model (
  input  wire logic       clk,
  input  wire logic [1:0] level,
  output logic      [1:0] pin
);
  // ************************************************
  // pin driver
  // ************************************************
  // pins move one edge after the command, like a synchronised source
  initial pin = 2'h0;
  always @(posedge clk) begin
    pin <= level;
  end
endmodule

// file: tb/eif_ctl_tb.sv
// self-checking bench for the two-channel external irq filter
`timescale 1ns/100ps
module eif_ctl_tb;
  // ************************************************
  // stimulus, monitors and helpers
  // ************************************************
  localparam int  LF_CYC = 16;
  localparam logic [11:0] A2 = eif_pkg::CH2_CONTROL_ADDR;
  localparam logic [11:0] A3 = eif_pkg::CH3_CONTROL_ADDR;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        slow = 1'b0;
  logic        lf = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  rdata;
  logic [1:0]  gate = 2'h0;
  logic [1:0]  lvl = 2'h0;
  logic [1:0]  pin;
  logic [1:0]  req;
  int          fails = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          n2 = 0;
  int          n3 = 0;
  int          b2 = 0;
  int          b3 = 0;
  int          l;

  always #12.5 clk = ~clk;

  eif_ctl #(.SAMPLES(eif_pkg::FILTER_SAMPLES)) u_dut (.CLK(clk), .RST(rst), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .CLOCK_GATE(gate), .SLOW_MODE(slow),
    .LF_CLK_IN(lf), .IRQ_PIN(pin), .IRQ_REQUEST(req));
  eif_pin_model u_pin (.clk(clk), .level(lvl), .pin(pin));

  // request counters, low-frequency clock and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    // low-frequency clock stepped on the rising edge like every other input
    if (cyc % (LF_CYC / 2) == 0) lf <= ~lf;
    if (req[0] === 1'b1) n2 <= n2 + 1;
    if (req[1] === 1'b1) n3 <= n3 + 1;
    if (cyc == 8000) begin
      fails++;
      end_of_test();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wreg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    // sampled mid-cycle where the data have settled, then back on the edge
    @(negedge clk);
    chk(rdata, exp);
    @(posedge clk);
  endtask
  // flip one pin and count cycles until its request shows
  task automatic tog_lat(input int b, output int n);
    @(posedge clk);
    lvl[b] <= ~lvl[b];
    n = 0;
    // look mid-cycle so the one-cycle pulse is seen settled
    do begin
      @(negedge clk);
      n++;
    end while (req[b] !== 1'b1 && n < 400);
    @(posedge clk);
  endtask
  function automatic int div_of(input int iv);
    return (iv == 0) ? 1 : (1 << (iv + 1));
  endfunction
  // latency window: pipeline slop on top of the agreeing samples
  function automatic logic [7:0] in_win(input int n, input int dv, input int slack);
    return 8'((n >= (eif_pkg::FILTER_SAMPLES - 1) * dv + 1) &&
              (n <= eif_pkg::FILTER_SAMPLES * dv + slack));
  endfunction
  function automatic logic [7:0] exp_cnt(input int e);
    return (e == 2) ? 8'h02 : (e == 3) ? 8'h00 : 8'h01;
  endfunction
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ************************************************
  // main sequence
  // ************************************************
  initial begin
    int s;
    s = $urandom(73483);
    idle(2);
    rst <= 1'b0;
    rchk(A2, eif_pkg::CONTROL_RESET);
    rchk(A3, eif_pkg::CONTROL_RESET);
    rchk(12'hfdb, 8'h00);
    wreg(A2, 8'h0f);
    rchk(A2, 8'h00);
    gate <= 2'h3;
    wreg(A2, 8'hff);
    rchk(A2, 8'h0f);
    $display("register test done");
    // every edge code, one rise then one fall
    for (int e = 0; e < 4; e++) begin
      wreg(A2, 8'(e << eif_pkg::EDGE_LSB));
      idle(8);
      b2 = n2;
      lvl[0] <= 1'b1;
      idle(12);
      lvl[0] <= 1'b0;
      idle(12);
      chk(8'(n2 - b2), exp_cnt(e));
      rchk(A2, {3'h0, e == 0, 2'(e), 2'h0});
    end
    $display("edge test done");
    // a two-cycle glitch must be swallowed
    wreg(A2, 8'h08);
    idle(8);
    b2 = n2;
    lvl[0] <= 1'b1;
    idle(2);
    lvl[0] <= 1'b0;
    idle(12);
    chk(8'(n2 - b2), 8'h00);
    for (int iv = 0; iv < 4; iv++) begin
      wreg(A2, {4'h0, eif_pkg::EDGE_BOTH, 2'(iv)});
      idle(40);
      tog_lat(0, l);
      chk(in_win(l, div_of(iv), 3), 8'h01);
    end
    $display("interval test done");
    // gate low clears the register and silences the channel
    gate <= 2'h2;
    idle(4);
    rchk(A2, 8'h00);
    b2 = n2;
    lvl[0] <= ~lvl[0];
    idle(40);
    chk(8'(n2 - b2), 8'h00);
    gate <= 2'h3;
    idle(2);
    wreg(A2, 8'h0b);
    slow <= 1'b1;
    idle(12 * LF_CYC); // requests in the switch are ignored
    tog_lat(0, l);
    chk(in_win(l, eif_pkg::SLOW_DIVIDE * LF_CYC, 20), 8'h01);
    slow <= 1'b0;
    idle(2 + 3 * LF_CYC);
    $display("gate and slow test done");
    // random hold times on channel 3, both edges
    wreg(A3, 8'h08);
    idle(8);
    b3 = n3;
    // odd count, so the level bit ends high after the last rise
    for (int k = 0; k < 25; k++) begin
      lvl[1] <= ~lvl[1];
      idle(4 + $urandom % 12);
    end
    idle(8);
    chk(8'(n3 - b3), 8'h19);
    rchk(A3, 8'h18);
    $display("random test done");
    end_of_test();
  end
endmodule
